// ### cwr_card.sv
`default_nettype none
module cwr_card (
  input  wire logic       inserted,            // Card seated.
  input  wire logic [1:0] sense,               // Sense levels, b then a.
  output wire logic       voltage_sense_pin_a, // Sense pin a.
  output wire logic       voltage_sense_pin_b, // Sense pin b.
  output wire logic       card_present_a_n,    // Detect a, low.
  output wire logic       card_present_b_n     // Detect b, low.
);
  // Socket pull-ups take every pin high once the card is gone.
  assign {voltage_sense_pin_b, voltage_sense_pin_a} = inserted ? sense : 2'h3;
  assign card_present_a_n = ~inserted;
  assign card_present_b_n = ~inserted;
endmodule // cwr_card
`default_nettype wire

// ### cwr_pkg.sv
`default_nettype none
package cwr_pkg;
  localparam int          NUM_WIN_DOC      = 5;
  localparam logic [7:0]  ADDR_CSC         = 8'h04;
  localparam logic [7:0]  ADDR_CSC_CFG     = 8'h05;
  localparam logic [7:0]  ADDR_DETECT_CTRL = 8'h16;
  localparam logic [7:0]  ADDR_GLOBAL      = 8'h1E;
  localparam logic [7:0]  ADDR_IRQ_STAT    = 8'h40;
  localparam logic [7:0]  ADDR_IRQ_MASK    = 8'h41;
  localparam logic [NUM_WIN_DOC-1:0][7:0] ADDR_WIN =
    {8'h35, 8'h2D, 8'h25, 8'h1D, 8'h15};

  localparam int BIT_WIN_WP         = 7;
  localparam int BIT_WIN_ATTR       = 6;
  localparam int BIT_SENSE2         = 7;
  localparam int BIT_SENSE1         = 6;
  localparam int BIT_SOFT_DETECT    = 5;
  localparam int BIT_WAKE_EN        = 4;
  localparam int BIT_REMOVAL_SEL    = 1;
  localparam int BIT_CSC_FLAG       = 0;
  localparam int BIT_DETECT_IRQ_EN  = 3;
  localparam int BIT_FLAG_CLEAR     = 2;
  localparam int IRQ_W              = 2;
  localparam int BIT_IRQ_DETECT     = 0;
  localparam int BIT_IRQ_SOFT       = 1;

  localparam logic [7:0]       RST_WIN  = 8'h00;
  localparam logic [IRQ_W-1:0] RST_IRQ  = 2'h0;
  localparam logic [1:0]       CD_EMPTY = 2'h3;
  localparam logic [1:0]       CD_FULL  = 2'h0;

  typedef struct packed {
    logic       write_protect;
    logic       attr_mem;
    logic [5:0] offset_upper_bits;
  } cwr_win_s;
endpackage
`default_nettype wire

// ### cwr_regs.sv
`default_nettype none
module cwr_regs
  import cwr_pkg::*;
#(
  parameter int NUM_WIN = NUM_WIN_DOC
) (
  input  wire logic                core_clk,              // Clock, 40 MHz.
  input  wire logic                sys_rst,               // Sync reset, high.
  input  wire logic [7:0]          reg_addr,              // Register address.
  input  wire logic [7:0]          reg_wdata,             // Write data.
  input  wire logic                reg_wr,                // Write strobe.
  input  wire logic                reg_rd,                // Read strobe.
  output logic      [7:0]          reg_rdata,             // Read data.
  input  wire logic                voltage_sense_pin_a,   // Sense pin a level.
  input  wire logic                voltage_sense_pin_b,   // Sense pin b level.
  input  wire logic                card_present_a_n,      // Detect a, low.
  input  wire logic                card_present_b_n,      // Detect b, low.
  input  wire logic [NUM_WIN-1:0]  win_wr_req,            // Host write via win.
  output logic      [NUM_WIN-1:0]  win_wr_allow,          // Write may proceed.
  output cwr_win_s  [NUM_WIN-1:0]  win_cfg,               // Window settings.
  output logic                     ring_indicate_output_n, // Wake, low.
  output logic                     irq                    // Level interrupt.
);

  initial begin
    if (NUM_WIN < 1 || NUM_WIN > NUM_WIN_DOC) begin
      $error("NUM_WIN out of range");
    end
  end

  logic [7:0]       win_ff [NUM_WIN];
  logic [7:0]       nxt_win [NUM_WIN];
  logic             wake_en_ff;
  logic             nxt_wake_en;
  logic             removal_sel_ff;
  logic             nxt_removal_sel;
  logic             detect_irq_en_ff;
  logic             nxt_detect_irq_en;
  logic             flag_clear_ff;
  logic             nxt_flag_clear;
  logic             csc_flag_ff;
  logic             nxt_csc_flag;
  logic             ring_low_ff;
  logic             nxt_ring_low;
  logic [1:0]       cd_prev_ff;
  logic [1:0]       nxt_cd_prev;
  logic             cd_valid_ff;
  logic             nxt_cd_valid;
  logic [IRQ_W-1:0] irq_stat_ff;
  logic [IRQ_W-1:0] nxt_irq_stat;
  logic [IRQ_W-1:0] irq_mask_ff;
  logic [IRQ_W-1:0] nxt_irq_mask;
  logic [7:0]       rdata_ff;
  logic [7:0]       nxt_rdata;

  logic [1:0] cd_now;
  logic       cd_change;
  logic       removal;
  logic       removal_rst;
  logic       soft_detect;
  logic       wr_ctrl;

  assign cd_now    = {card_present_b_n, card_present_a_n};
  assign cd_change = cd_valid_ff && (cd_now != cd_prev_ff);
  // A removal is a fully seated card losing either detect contact.
  assign removal   = cd_change && (cd_prev_ff == CD_FULL);
  assign removal_rst = removal && removal_sel_ff;
  assign wr_ctrl   = reg_wr && (reg_addr == ADDR_DETECT_CTRL);
  assign soft_detect = wr_ctrl && reg_wdata[BIT_SOFT_DETECT]
                       && detect_irq_en_ff;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_WIN; gi++) begin : g_win
      always_comb begin
        nxt_win[gi] = win_ff[gi];
        if (removal_rst) begin
          nxt_win[gi] = RST_WIN;
        end else if (reg_wr && reg_addr == ADDR_WIN[gi]) begin
          nxt_win[gi] = reg_wdata;
        end
      end

      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          win_ff[gi] <= RST_WIN;
        end else begin
          win_ff[gi] <= nxt_win[gi];
        end
      end

      assign win_cfg[gi].write_protect     = win_ff[gi][BIT_WIN_WP];
      assign win_cfg[gi].attr_mem          = win_ff[gi][BIT_WIN_ATTR];
      assign win_cfg[gi].offset_upper_bits = win_ff[gi][5:0];
      assign win_wr_allow[gi] = win_wr_req[gi]
                                && !win_ff[gi][BIT_WIN_WP];
    end
  endgenerate

  always_comb begin
    nxt_wake_en       = wake_en_ff;
    nxt_removal_sel   = removal_sel_ff;
    nxt_detect_irq_en = detect_irq_en_ff;
    nxt_flag_clear    = flag_clear_ff;
    nxt_irq_mask      = irq_mask_ff;
    if (removal_rst) begin
      nxt_wake_en       = 1'b0;
      nxt_removal_sel   = 1'b0;
      nxt_detect_irq_en = 1'b0;
      nxt_flag_clear    = 1'b0;
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_DETECT_CTRL: begin
          nxt_wake_en     = reg_wdata[BIT_WAKE_EN];
          nxt_removal_sel = reg_wdata[BIT_REMOVAL_SEL];
        end
        ADDR_CSC_CFG: nxt_detect_irq_en = reg_wdata[BIT_DETECT_IRQ_EN];
        ADDR_GLOBAL:  nxt_flag_clear    = reg_wdata[BIT_FLAG_CLEAR];
        ADDR_IRQ_MASK: nxt_irq_mask     = reg_wdata[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // The flag is set by a real detect change or by the software trigger, and
  // a set in the same cycle as a clear keeps the flag so no event is lost.
  always_comb begin
    nxt_csc_flag = csc_flag_ff;
    if (!flag_clear_ff && reg_rd && reg_addr == ADDR_CSC) begin
      nxt_csc_flag = 1'b0;
    end
    if (flag_clear_ff && reg_wr && reg_addr == ADDR_CSC
        && reg_wdata[BIT_CSC_FLAG]) begin
      nxt_csc_flag = 1'b0;
    end
    if (cd_change || soft_detect) begin
      nxt_csc_flag = 1'b1;
    end
  end

  always_comb begin
    nxt_ring_low = ring_low_ff;
    if (ring_low_ff) begin
      nxt_ring_low = nxt_csc_flag;
    end else if (cd_change && wake_en_ff) begin
      nxt_ring_low = 1'b1;
    end
  end

  always_comb begin
    nxt_irq_stat = irq_stat_ff;
    if (reg_wr && reg_addr == ADDR_IRQ_STAT) begin
      nxt_irq_stat = irq_stat_ff & ~reg_wdata[IRQ_W-1:0];
    end
    if (cd_change) begin
      nxt_irq_stat[BIT_IRQ_DETECT] = 1'b1;
    end
    if (soft_detect) begin
      nxt_irq_stat[BIT_IRQ_SOFT] = 1'b1;
    end
  end

  always_comb begin
    nxt_cd_prev  = cd_now;
    nxt_cd_valid = 1'b1;
  end

  always_comb begin
    nxt_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_DETECT_CTRL: begin
          // Soft trigger and reserved bits stay zero here.
          nxt_rdata[BIT_SENSE2]      = voltage_sense_pin_b;
          nxt_rdata[BIT_SENSE1]      = voltage_sense_pin_a;
          nxt_rdata[BIT_WAKE_EN]     = wake_en_ff;
          nxt_rdata[BIT_REMOVAL_SEL] = removal_sel_ff;
        end
        ADDR_CSC:      nxt_rdata[BIT_CSC_FLAG]      = csc_flag_ff;
        ADDR_CSC_CFG:  nxt_rdata[BIT_DETECT_IRQ_EN] = detect_irq_en_ff;
        ADDR_GLOBAL:   nxt_rdata[BIT_FLAG_CLEAR]    = flag_clear_ff;
        ADDR_IRQ_STAT: nxt_rdata[IRQ_W-1:0]         = irq_stat_ff;
        ADDR_IRQ_MASK: nxt_rdata[IRQ_W-1:0]         = irq_mask_ff;
        default: begin
          for (int i = 0; i < NUM_WIN; i++) begin
            if (reg_addr == ADDR_WIN[i]) begin
              nxt_rdata = win_ff[i];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wake_en_ff       <= 1'b0;
      removal_sel_ff   <= 1'b0;
      detect_irq_en_ff <= 1'b0;
      flag_clear_ff    <= 1'b0;
      csc_flag_ff      <= 1'b0;
      ring_low_ff      <= 1'b0;
      cd_prev_ff       <= CD_EMPTY;
      cd_valid_ff      <= 1'b0;
      irq_stat_ff      <= RST_IRQ;
      irq_mask_ff      <= RST_IRQ;
      rdata_ff         <= 8'h00;
    end else begin
      wake_en_ff       <= nxt_wake_en;
      removal_sel_ff   <= nxt_removal_sel;
      detect_irq_en_ff <= nxt_detect_irq_en;
      flag_clear_ff    <= nxt_flag_clear;
      csc_flag_ff      <= nxt_csc_flag;
      ring_low_ff      <= nxt_ring_low;
      cd_prev_ff       <= nxt_cd_prev;
      cd_valid_ff      <= nxt_cd_valid;
      irq_stat_ff      <= nxt_irq_stat;
      irq_mask_ff      <= nxt_irq_mask;
      rdata_ff         <= nxt_rdata;
    end
  end

  assign reg_rdata              = rdata_ff;
  assign ring_indicate_output_n = !ring_low_ff;
  assign irq                    = |(irq_stat_ff & irq_mask_ff);

endmodule // cwr_regs
`default_nettype wire

// ### cwr_regs_chk.sv
`default_nettype none
module cwr_regs_chk
  import cwr_pkg::*;
#(
  parameter int NUM_WIN = 5
) (
  input wire logic               core_clk,               // Clock.
  input wire logic               sys_rst,                // Reset.
  input wire logic [7:0]         reg_addr,               // Address.
  input wire logic [7:0]         reg_wdata,              // Write data.
  input wire logic               reg_wr,                 // Write strobe.
  input wire logic               reg_rd,                 // Read strobe.
  input wire logic [7:0]         reg_rdata,              // Read data.
  input wire logic               voltage_sense_pin_a,    // Sense a.
  input wire logic               voltage_sense_pin_b,    // Sense b.
  input wire logic               card_present_a_n,       // Detect a.
  input wire logic               card_present_b_n,       // Detect b.
  input wire logic [NUM_WIN-1:0] win_wr_req,             // Write tries.
  input wire logic [NUM_WIN-1:0] win_wr_allow,           // Writes let.
  input wire cwr_win_s [NUM_WIN-1:0] win_cfg,            // Settings.
  input wire logic               ring_indicate_output_n, // Wake.
  input wire logic               irq                     // Interrupt.
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire logic [1:0] det = {card_present_b_n, card_present_a_n};
  wire logic csc_hit = (reg_rd | reg_wr) && reg_addr == ADDR_CSC;
  wire logic ring_n = ring_indicate_output_n;

  AST_WIN_WP: assert property (win_wr_allow[0] ==
    (win_wr_req[0] & ~win_cfg[0].write_protect)) else $error("bad allow");
  AST_WIN_WR: assert property (reg_wr && reg_addr == ADDR_WIN[0]
    |=> win_cfg[0] == $past(reg_wdata)) else $error("bad window");
  AST_RD_WIN: assert property (reg_rd && reg_addr == ADDR_WIN[0]
    |=> reg_rdata == $past(win_cfg[0])) else $error("bad window read");
  AST_RD_CTRL: assert property (reg_rd && reg_addr == ADDR_DETECT_CTRL
    |=> reg_rdata[7:6] == $past({voltage_sense_pin_b, voltage_sense_pin_a})
    && reg_rdata[5] == 1'b0 && reg_rdata[3:2] == 2'h0 && !reg_rdata[0])
    else $error("bad control read");
  AST_RING_FALL: assert property ($fell(ring_n)
    |-> $past(det) != $past(det, 2)) else $error("ring fell alone");
  // One spare cycle, since the output may be registered off the flag.
  AST_RING_HOLD: assert property (!ring_n && !csc_hit && !$past(csc_hit)
    |=> !ring_n) else $error("ring released early");
  AST_IRQ_MASK: assert property (reg_wr && reg_addr == ADDR_IRQ_MASK
    && reg_wdata == 8'h00 |-> ##[1:2] !irq) else $error("masked irq");
  AST_RST_VAL: assert property (disable iff (1'b0) sys_rst
    |=> ring_n && !irq && win_cfg == '0) else $error("bad reset");

  COV_RING: cover property ($fell(ring_n));
  COV_IRQ: cover property ($rose(irq));
  COV_WP: cover property (win_wr_req[0] && !win_wr_allow[0]);
endmodule // cwr_regs_chk

bind cwr_regs cwr_regs_chk #(.NUM_WIN(NUM_WIN)) i_chk (.*);
`default_nettype wire

// ### tb_top.sv
`default_nettype none
module tb_top
  import cwr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, lf = 8'h4F;
  logic [4:0] win_wr_req = 5'h1F, win_wr_allow;
  cwr_win_s [4:0] win_cfg;
  logic ring_indicate_output_n, irq, inserted = 1'b1, rd_seen = 1'b0;
  logic [1:0] sense = 2'h0;
  logic [15:0] t;
  wire logic voltage_sense_pin_a, voltage_sense_pin_b;
  wire logic card_present_a_n, card_present_b_n;
  logic [15:0] exp_q[$];
  int err_count = 0, n_checks = 0, cyc = 0;

  cwr_regs #(.NUM_WIN(5)) i_dut (.*);
  cwr_card i_card (.*);
  always #12.5 core_clk = ~core_clk;

  function automatic logic [7:0] lfsr(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(logic [7:0] seen, logic [7:0] want);
    n_checks++;
    if (seen !== want) begin
      err_count++;
      $display("Error %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic nap(int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // A zero mask byte marks a read whose value is not predicted.
  task automatic rd(logic [7:0] a, logic [7:0] m, logic [7:0] e);
    exp_q.push_back({m, e});
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask
  task automatic wr_irq(logic [7:0] a, logic [7:0] d, logic e);
    wr(a, d);
    nap(2);
    check(8'(irq), 8'(e));
  endtask
  task automatic ring_is(int n, logic e);
    nap(n);
    check(8'(ring_indicate_output_n), 8'(e));
  endtask
  task automatic card(logic v);
    @(posedge core_clk);
    inserted <= v;
  endtask

  always @(posedge core_clk) begin
    if (rd_seen) begin
      t = exp_q.pop_front();
      check(reg_rdata & t[15:8], t[7:0]);
    end
    rd_seen <= reg_rd;
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_count++;
      stop_test();
    end
  end

  initial begin
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 5; i++) rd(ADDR_WIN[i], 8'hFF, 8'h00);
    rd(8'hFF, 8'hFF, 8'h00);
    wr(ADDR_IRQ_MASK, 8'h03);
    for (int i = 0; i < 5; i++) begin
      lf = lfsr(lf);
      wr(ADDR_WIN[i], {i[0], lf[6:0]});
      rd(ADDR_WIN[i], 8'hFF, {i[0], lf[6:0]});
      nap(1);
      check(win_cfg[i], {i[0], lf[6:0]});
      check(8'(win_wr_allow[i]), 8'(!i[0]));
    end
    wr(ADDR_DETECT_CTRL, 8'h3F);
    for (int s = 0; s < 4; s++) begin
      sense <= s[1:0];
      rd(ADDR_DETECT_CTRL, 8'hFF, {s[1:0], 6'h12});
    end
    rd(ADDR_IRQ_STAT, 8'hFF, 8'h00);
    wr(ADDR_CSC_CFG, 8'h08);
    wr_irq(ADDR_DETECT_CTRL, 8'h32, 1'b1);
    rd(ADDR_IRQ_STAT, 8'h02, 8'h02);
    wr_irq(ADDR_IRQ_STAT, 8'h03, 1'b0);
    rd(ADDR_CSC, 8'h00, 8'h00);
    card(1'b0);
    ring_is(3, 1'b0);
    check(win_cfg[1], 8'h00);
    ring_is(4, 1'b0);
    wr_irq(ADDR_IRQ_MASK, 8'h00, 1'b0);
    wr_irq(ADDR_IRQ_MASK, 8'h03, 1'b1);
    wr_irq(ADDR_IRQ_STAT, 8'h01, 1'b0);
    rd(ADDR_CSC, 8'h01, 8'h01);
    ring_is(3, 1'b1);
    wr(ADDR_WIN[0], 8'h25);
    card(1'b1);
    ring_is(4, 1'b1);
    card(1'b0);
    ring_is(4, 1'b1);
    check(win_cfg[0], 8'h25);
    wr(ADDR_GLOBAL, 8'h04);
    wr(ADDR_CSC, 8'h01);
    wr(ADDR_DETECT_CTRL, 8'h10);
    card(1'b1);
    ring_is(3, 1'b0);
    rd(ADDR_CSC, 8'h01, 8'h01);
    ring_is(3, 1'b0);
    wr(ADDR_CSC, 8'h01);
    ring_is(3, 1'b1);
    nap(2);
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
